// *** hw/aux_mix_defines.svh ***
// Register addresses, field positions and reset values for the aux bank
`ifndef AUX_MIX_DEFINES_SVH
`define AUX_MIX_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define PWR2_ADDR     8'h09
`define LMIX_ADDR     8'h5c
`define RMIX_ADDR     8'h5d

// ----------------------------------------
// Left aux mixer fields
// ----------------------------------------
`define LMIX_ENA_BIT  15
`define LMIX_LCONV    11
`define LMIX_LINMIX   8
`define LMIX_RAUX     3
`define LMIX_LOUTMIX  0
`define LMIX_MASK     16'h8909

// ----------------------------------------
// Right aux mixer fields
// ----------------------------------------
`define RMIX_ENA_BIT  15
`define RMIX_RCONV    12
`define RMIX_LCONV    11
`define RMIX_ATT      10
`define RMIX_RINMIX   9
`define RMIX_LAUX     2
`define RMIX_ROUTMIX  1
`define RMIX_LOUTMIX  0
`define RMIX_MASK     16'h9e07

// ----------------------------------------
// Power management fields
// ----------------------------------------
`define PWR2_LENA     4
`define PWR2_RENA     5
`define PWR2_MASK     16'h0030

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RST       13'h0000
`define WORD_ZERO     16'h0000
`define STATUS_RST    2'h0

// ----------------------------------------
// Mixer word with the enable alone, no path selected
// ----------------------------------------
`define AUX_ENA_ONLY  16'h8000

`endif

// *** hw/aux_mix_pkg.sv ***
// Types shared by the aux output mixer configuration bank
package aux_mix_pkg;

  // Every stored control bit of the two aux mixers
  typedef struct packed {
    logic left_aux_enable;
    logic left_conv_to_left_aux_sel;
    logic left_inmix_to_left_aux_sel;
    logic right_aux_into_left_aux_sel;
    logic left_outmix_to_left_aux_sel;
    logic right_aux_enable;
    logic right_conv_to_right_aux_sel;
    logic left_conv_to_right_aux_sel;
    logic right_aux_attenuate;
    logic right_inmix_to_right_aux_sel;
    logic left_aux_into_right_aux_sel;
    logic right_outmix_to_right_aux_sel;
    logic left_outmix_to_right_aux_sel;
  } aux_cfg_type;

  // Status of the two outputs seen by the analogue side
  typedef struct packed {
    logic left_aux_pseudo_ground;
    logic right_aux_pseudo_ground;
  } aux_status_type;

endpackage

// *** hw/aux_switch_drive.sv ***
// Registered drive of the analogue switch controls for both aux outputs
`timescale 1ns/1ns
`include "aux_mix_defines.svh"

module aux_switch_drive (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire aux_mix_pkg::aux_cfg_type cfg,
  output aux_mix_pkg::aux_cfg_type    switch_ctrl,
  output aux_mix_pkg::aux_status_type status
);

  aux_mix_pkg::aux_cfg_type    sw_r;
  aux_mix_pkg::aux_cfg_type    sw_nxt;
  aux_mix_pkg::aux_status_type st_r;
  aux_mix_pkg::aux_status_type st_nxt;

  // Switch image and pseudo-ground detection
  always_comb begin
    sw_nxt = cfg;
    // Crossover path is unsupported, never close that switch
    sw_nxt.left_aux_into_right_aux_sel = 1'b0;
    // Enabled with no path selected: output drives midrail only
    st_nxt.left_aux_pseudo_ground = cfg.left_aux_enable &&
      !(cfg.left_conv_to_left_aux_sel ||
        cfg.left_inmix_to_left_aux_sel ||
        cfg.right_aux_into_left_aux_sel ||
        cfg.left_outmix_to_left_aux_sel);
    st_nxt.right_aux_pseudo_ground = cfg.right_aux_enable &&
      !(cfg.right_conv_to_right_aux_sel ||
        cfg.left_conv_to_right_aux_sel ||
        cfg.right_inmix_to_right_aux_sel ||
        cfg.left_aux_into_right_aux_sel ||
        cfg.right_outmix_to_right_aux_sel ||
        cfg.left_outmix_to_right_aux_sel);
  end

  // Output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_r <= `CFG_RST;
      st_r <= `STATUS_RST;
    end else begin
      sw_r <= sw_nxt;
      st_r <= st_nxt;
    end
  end

  assign switch_ctrl = sw_r;
  assign status      = st_r;

endmodule

// *** hw/aux_output_mixer_config_regs.sv ***
// Configuration register bank for the two aux analogue outputs
`timescale 1ns/1ns
`include "aux_mix_defines.svh"

module aux_output_mixer_config_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [DATA_W-1:0]       wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [DATA_W-1:0]       rdata,
  output aux_mix_pkg::aux_cfg_type     switch_ctrl,
  output aux_mix_pkg::aux_status_type  status
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  aux_mix_pkg::aux_cfg_type cfg_r;
  aux_mix_pkg::aux_cfg_type cfg_nxt;
  logic [DATA_W-1:0]        rdata_r;
  logic [DATA_W-1:0]        rdata_nxt;

  // Compose the read word of one register; unmapped reads zero
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0]     a,
    input aux_mix_pkg::aux_cfg_type c
  );
    logic [DATA_W-1:0] w;
    w = `WORD_ZERO;
    if (a == `LMIX_ADDR) begin
      w[`LMIX_ENA_BIT] = c.left_aux_enable;
      w[`LMIX_LCONV]   = c.left_conv_to_left_aux_sel;
      w[`LMIX_LINMIX]  = c.left_inmix_to_left_aux_sel;
      w[`LMIX_RAUX]    = c.right_aux_into_left_aux_sel;
      w[`LMIX_LOUTMIX] = c.left_outmix_to_left_aux_sel;
    end else if (a == `RMIX_ADDR) begin
      w[`RMIX_ENA_BIT] = c.right_aux_enable;
      w[`RMIX_RCONV]   = c.right_conv_to_right_aux_sel;
      w[`RMIX_LCONV]   = c.left_conv_to_right_aux_sel;
      w[`RMIX_ATT]     = c.right_aux_attenuate;
      w[`RMIX_RINMIX]  = c.right_inmix_to_right_aux_sel;
      w[`RMIX_LAUX]    = c.left_aux_into_right_aux_sel;
      w[`RMIX_ROUTMIX] = c.right_outmix_to_right_aux_sel;
      w[`RMIX_LOUTMIX] = c.left_outmix_to_right_aux_sel;
    end else if (a == `PWR2_ADDR) begin
      w[`PWR2_LENA]    = c.left_aux_enable;
      w[`PWR2_RENA]    = c.right_aux_enable;
    end
    return w;
  endfunction

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  // Only defined field bits are taken; other write bits fall away
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_stb) begin
      if (addr == `LMIX_ADDR) begin
        cfg_nxt.left_aux_enable = wdata[`LMIX_ENA_BIT];
        cfg_nxt.left_conv_to_left_aux_sel =
          wdata[`LMIX_LCONV];
        cfg_nxt.left_inmix_to_left_aux_sel =
          wdata[`LMIX_LINMIX];
        cfg_nxt.right_aux_into_left_aux_sel =
          wdata[`LMIX_RAUX];
        cfg_nxt.left_outmix_to_left_aux_sel =
          wdata[`LMIX_LOUTMIX];
      end else if (addr == `RMIX_ADDR) begin
        cfg_nxt.right_aux_enable = wdata[`RMIX_ENA_BIT];
        cfg_nxt.right_conv_to_right_aux_sel =
          wdata[`RMIX_RCONV];
        cfg_nxt.left_conv_to_right_aux_sel =
          wdata[`RMIX_LCONV];
        cfg_nxt.right_aux_attenuate = wdata[`RMIX_ATT];
        cfg_nxt.right_inmix_to_right_aux_sel =
          wdata[`RMIX_RINMIX];
        // Stored for readback and the right pseudo-ground flag; the switch stays open
        cfg_nxt.left_aux_into_right_aux_sel = wdata[`RMIX_LAUX];
        cfg_nxt.right_outmix_to_right_aux_sel =
          wdata[`RMIX_ROUTMIX];
        cfg_nxt.left_outmix_to_right_aux_sel =
          wdata[`RMIX_LOUTMIX];
      end else if (addr == `PWR2_ADDR) begin
        cfg_nxt.left_aux_enable  = wdata[`PWR2_LENA];
        cfg_nxt.right_aux_enable = wdata[`PWR2_RENA];
      end
    end
  end

  // Configuration storage, all fields clear at reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= `CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data stand only in the cycle after the strobe
  always_comb begin
    rdata_nxt = `WORD_ZERO;
    if (rd_stb) begin
      rdata_nxt = read_word(addr, cfg_r);
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= `WORD_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ----------------------------------------
  // Analogue switch drive
  // ----------------------------------------
  aux_switch_drive u_drive (
    .clk         (clk),
    .arst_n      (arst_n),
    .cfg         (cfg_r),
    .switch_ctrl (switch_ctrl),
    .status      (status)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic wr_l;
  logic wr_r;
  logic wr_p;
  logic rd_l;
  logic rd_r;
  logic rd_p;
  logic rd_none;
  logic wr_none;
  // Strobe decode per register index for the checks
  assign wr_l = wr_stb && (addr == `LMIX_ADDR);
  assign wr_r = wr_stb && (addr == `RMIX_ADDR);
  assign wr_p = wr_stb && (addr == `PWR2_ADDR);
  assign rd_l = rd_stb && (addr == `LMIX_ADDR);
  assign rd_r = rd_stb && (addr == `RMIX_ADDR);
  assign rd_p = rd_stb && (addr == `PWR2_ADDR);
  assign rd_none = rd_stb && !(addr == `LMIX_ADDR ||
    addr == `RMIX_ADDR || addr == `PWR2_ADDR);
  assign wr_none = wr_stb && !(addr == `LMIX_ADDR ||
    addr == `RMIX_ADDR || addr == `PWR2_ADDR);

  lconv_path_a: assert property (
    wr_l |-> ##2 (switch_ctrl.left_conv_to_left_aux_sel ==
      $past(wdata[`LMIX_LCONV], 2)) &&
      (switch_ctrl.left_inmix_to_left_aux_sel ==
      $past(wdata[`LMIX_LINMIX], 2)))
    else $error("left mixer converter or input path wrong");

  lmix_other_a: assert property (
    wr_l |-> ##2 (switch_ctrl.right_aux_into_left_aux_sel ==
      $past(wdata[`LMIX_RAUX], 2)) &&
      (switch_ctrl.left_outmix_to_left_aux_sel ==
      $past(wdata[`LMIX_LOUTMIX], 2)))
    else $error("left mixer aux or output mixer path wrong");

  lena_alias_a: assert property (
    wr_l ##1 rd_p |=>
      rdata[`PWR2_LENA] == $past(wdata[`LMIX_ENA_BIT], 2))
    else $error("left enable not seen in power register");

  rena_alias_a: assert property (
    wr_p ##1 rd_r |=>
      rdata[`RMIX_ENA_BIT] == $past(wdata[`PWR2_RENA], 2))
    else $error("right enable not seen in right mixer");

  rconv_path_a: assert property (
    wr_r |-> ##2 (switch_ctrl.right_conv_to_right_aux_sel ==
      $past(wdata[`RMIX_RCONV], 2)) &&
      (switch_ctrl.left_conv_to_right_aux_sel ==
      $past(wdata[`RMIX_LCONV], 2)))
    else $error("right mixer converter paths wrong");

  ratt_half_a: assert property (
    wr_r |-> ##2 switch_ctrl.right_aux_attenuate ==
      $past(wdata[`RMIX_ATT], 2))
    else $error("right attenuation not applied");

  rinmix_path_a: assert property (
    wr_r |-> ##2 switch_ctrl.right_inmix_to_right_aux_sel ==
      $past(wdata[`RMIX_RINMIX], 2))
    else $error("right input mixer path wrong");

  routmix_path_a: assert property (
    wr_r |-> ##2 (switch_ctrl.right_outmix_to_right_aux_sel ==
      $past(wdata[`RMIX_ROUTMIX], 2)) &&
      (switch_ctrl.left_outmix_to_right_aux_sel ==
      $past(wdata[`RMIX_LOUTMIX], 2)))
    else $error("right output mixer paths wrong");

  pseudo_gnd_a: assert property (
    (wr_l && wdata == `AUX_ENA_ONLY) ##1 !wr_stb |=>
      status.left_aux_pseudo_ground)
    else $error("left pseudo ground not flagged");

  reserved_zero_a: assert property (
    rd_l |=> (rdata & ~`LMIX_MASK) == `WORD_ZERO)
    else $error("left mixer reserved bits not zero");

  rmix_reserved_a: assert property (
    rd_r |=> (rdata & ~`RMIX_MASK) == `WORD_ZERO)
    else $error("right mixer reserved bits not zero");

  unmapped_zero_a: assert property (
    (rd_none || !rd_stb) |=> rdata == `WORD_ZERO)
    else $error("read data outside the answer cycle");

  cross_open_a: assert property (
    !switch_ctrl.left_aux_into_right_aux_sel)
    else $error("crossover switch closed");

  // Enable bits taken from whichever location was written
  lena_wr_a: assert property (
    wr_l |-> ##2 switch_ctrl.left_aux_enable ==
      $past(wdata[`LMIX_ENA_BIT], 2))
    else $error("left enable not taken from left mixer");

  rena_wr_a: assert property (
    wr_r |-> ##2 switch_ctrl.right_aux_enable ==
      $past(wdata[`RMIX_ENA_BIT], 2))
    else $error("right enable not taken from right mixer");

  pwr_ena_wr_a: assert property (
    wr_p |-> ##2 (switch_ctrl.left_aux_enable ==
      $past(wdata[`PWR2_LENA], 2)) &&
      (switch_ctrl.right_aux_enable ==
      $past(wdata[`PWR2_RENA], 2)))
    else $error("enables not taken from power register");

  // A write to one mixer leaves the other output alone
  lmix_keep_a: assert property (
    wr_l |-> ##2 $stable(switch_ctrl.right_aux_enable))
    else $error("left mixer write moved the right enable");

  rconv_keep_a: assert property (
    wr_l |-> ##2 $stable(switch_ctrl.right_conv_to_right_aux_sel))
    else $error("left mixer write moved a right path");

  rmix_keep_a: assert property (
    wr_r |-> ##2 $stable(switch_ctrl.left_aux_enable))
    else $error("right mixer write moved the left enable");

  // The power register carries no path selects
  pwr_keep_a: assert property (
    wr_p |-> ##2 $stable(switch_ctrl.left_outmix_to_left_aux_sel) &&
      $stable(switch_ctrl.right_outmix_to_right_aux_sel))
    else $error("power register write moved a path select");

  unmapped_wr_a: assert property (
    wr_none |-> ##2 $stable(switch_ctrl))
    else $error("unmapped write changed the bank");

  pwr_reserved_a: assert property (
    rd_p |=> (rdata & ~`PWR2_MASK) == `WORD_ZERO)
    else $error("power register reserved bits not zero");

  // Pseudo-ground flags follow the path selects
  rpseudo_gnd_a: assert property (
    (wr_r && wdata == `AUX_ENA_ONLY) ##1 !wr_stb |=>
      status.right_aux_pseudo_ground)
    else $error("right pseudo ground not flagged");

  lpath_no_gnd_a: assert property (
    (wr_l && wdata[`LMIX_LOUTMIX]) ##1 !wr_stb |=>
      !status.left_aux_pseudo_ground)
    else $error("left pseudo ground with a path selected");

  // Main scenarios
  cov_lmix_wr: cover property (wr_l ##1 rd_l);
  cov_alias:   cover property (wr_p ##1 rd_r);
  cov_b2b:     cover property (wr_l ##1 rd_p);
  cov_mono:    cover property (wr_r ##2
    switch_ctrl.right_aux_attenuate);
  cov_pground: cover property (status.right_aux_pseudo_ground);

endmodule

// *** verification/test_aux_output_mixer_config_regs.sv ***
// Self-checking bench for the aux output mixer configuration bank
`timescale 1ns/1ns

module test_aux_output_mixer_config_regs;
  logic                        clk;
  logic                        arst_n;
  logic [7:0]                  addr;
  logic [15:0]                 wdata;
  logic                        wr_stb;
  logic                        rd_stb;
  logic [15:0]                 rdata;
  aux_mix_pkg::aux_cfg_type    switch_ctrl;
  aux_mix_pkg::aux_status_type status;
  aux_mix_pkg::aux_cfg_type    exp_sw;
  int                          n_fail;
  int                          total_checks;

  // Design under test
  aux_output_mixer_config_regs #(.ADDR_W(8), .DATA_W(16)) dut_u (
    .clk         (clk),
    .arst_n      (arst_n),
    .addr        (addr),
    .wdata       (wdata),
    .wr_stb      (wr_stb),
    .rd_stb      (rd_stb),
    .rdata       (rdata),
    .switch_ctrl (switch_ctrl),
    .status      (status)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // One-cycle read; data is judged in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
                        input string what);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask

  // Write followed at once by a read, with no idle cycle between
  task automatic wr_rd(input logic [7:0] wa, input logic [15:0] wd,
                       input logic [7:0] ra, input logic [15:0] exp,
                       input string what);
    @(posedge clk);
    addr   <= wa;
    wdata  <= wd;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr   <= ra;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask

  // Switch controls follow a write two edges later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic chk_sw();
    chk("switch_ctrl", {3'h0, switch_ctrl}, {3'h0, exp_sw});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Everything clear after reset
  task automatic t_reset();
    exp_sw = '0;
    chk_sw();
    chk("status", {14'h0, status}, 16'h0000);
    rd_chk(8'h09, 16'h0000, "pwr");
    rd_chk(8'h5c, 16'h0000, "lmix");
    rd_chk(8'h5d, 16'h0000, "rmix");
  endtask

  // All ones into the left mixer: defined bits only stick
  task automatic t_left();
    wr(8'h5c, 16'hffff);
    settle();
    exp_sw.left_aux_enable             = 1'b1;
    exp_sw.left_conv_to_left_aux_sel   = 1'b1;
    exp_sw.left_inmix_to_left_aux_sel  = 1'b1;
    exp_sw.right_aux_into_left_aux_sel = 1'b1;
    exp_sw.left_outmix_to_left_aux_sel = 1'b1;
    chk_sw();
    rd_chk(8'h5c, 16'h8909, "lmix");
    rd_chk(8'h09, 16'h0010, "pwr");
  endtask

  // All ones into the right mixer; the crossover bit is left clear
  task automatic t_right();
    wr(8'h5d, 16'hfffb);
    settle();
    exp_sw.right_aux_enable              = 1'b1;
    exp_sw.right_conv_to_right_aux_sel   = 1'b1;
    exp_sw.left_conv_to_right_aux_sel    = 1'b1;
    exp_sw.right_aux_attenuate           = 1'b1;
    exp_sw.right_inmix_to_right_aux_sel  = 1'b1;
    exp_sw.right_outmix_to_right_aux_sel = 1'b1;
    exp_sw.left_outmix_to_right_aux_sel  = 1'b1;
    chk_sw();
    rd_chk(8'h5d, 16'h9e03, "rmix");
    rd_chk(8'h09, 16'h0030, "pwr");
  endtask

  // Enables written through the power register show in the mixers
  task automatic t_alias();
    wr(8'h09, 16'hffcf);
    settle();
    exp_sw.left_aux_enable  = 1'b0;
    exp_sw.right_aux_enable = 1'b0;
    chk_sw();
    rd_chk(8'h5c, 16'h0909, "lmix");
    rd_chk(8'h5d, 16'h1e03, "rmix");
    rd_chk(8'h09, 16'h0000, "pwr");
    wr(8'h09, 16'h0020);
    rd_chk(8'h5d, 16'h9e03, "rmix");
    rd_chk(8'h5c, 16'h0909, "lmix");
    wr_rd(8'h5c, 16'h8909, 8'h09, 16'h0030, "pwr");
    wr_rd(8'h09, 16'h0010, 8'h5d, 16'h1e03, "rmix");
  endtask

  // Enabled output with no path selected acts as pseudo-ground
  task automatic t_ground();
    wr(8'h5c, 16'h8000);
    wr(8'h5d, 16'h0000);
    settle();
    chk("status", {14'h0, status}, 16'h0002);
    wr(8'h5d, 16'h8000);
    settle();
    chk("status", {14'h0, status}, 16'h0003);
    wr(8'h5c, 16'h8001);
    settle();
    chk("status", {14'h0, status}, 16'h0001);
  endtask

  // Unmapped places read zero and disturb nothing; read data is one cycle
  task automatic t_unmapped();
    wr(8'h5e, 16'hffff);
    wr(8'h00, 16'hffff);
    rd_chk(8'h5e, 16'h0000, "unmapped");
    rd_chk(8'h5d, 16'h8000, "rmix");
    @(posedge clk);
    #1;
    chk("rdata_idle", rdata, 16'h0000);
  endtask

  // Reset in mid-run clears the bank again
  task automatic t_rereset();
    wr(8'h5c, 16'hffff);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("switch_ctrl", {3'h0, switch_ctrl}, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(8'h5c, 16'h0000, "lmix");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    n_fail       = 0;
    total_checks = 0;
    arst_n       = 1'b0;
    addr         = 8'h00;
    wdata        = 16'h0000;
    wr_stb       = 1'b0;
    rd_stb       = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_left();
    t_right();
    t_alias();
    t_ground();
    t_unmapped();
    t_rereset();
    test_done();
  end

  // Watchdog well beyond the fewer than 100 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
